// ---- dacf_regs.svh ----
// register map, field positions, reset values and timing counts
// ---------------------------------------------------------------
// Behaviour
// - word clock tracks the system clock; no fixed phase between them
// - external mode takes right-justified words of 16, 20 or 24 bits
// - modulator rate code: 00 eight, 01 four, 10 sixteen word clocks
// - total oversampling is filter factor times modulator factor
// - bits disabled for the active mode have no effect
// - external mode keeps only its listed register functions
// - bitstream mode picks one of four FIR responses by two bits
// - bitstream mode reuses data and bit clock pins
// - bitstream path keeps working with the system clock stopped
// - bitstream FIR runs at full bit rate for 00, half for 01
// - bitstream mode keeps only its listed register functions
// - external zero flag after 1024 zero words when enabled
// - bitstream zero flag on even or fixed pattern for 200 ms
// ---------------------------------------------------------------
`ifndef DACF_REGS_SVH
`define DACF_REGS_SVH

`define DACF_ADDR_R16 7'h10
`define DACF_ADDR_R17 7'h11
`define DACF_ADDR_R18 7'h12
`define DACF_ADDR_R19 7'h13
`define DACF_ADDR_R20 7'h14
`define DACF_ADDR_R21 7'h15
`define DACF_ADDR_R22 7'h16

`define DACF_R18_FMT_LSB 4
`define DACF_R18_DMF_LSB 2
`define DACF_R19_REV 7
`define DACF_R19_OPE 4
`define DACF_R19_BYPASS_STEREO_SEL 2
`define DACF_R19_ZERO_HOLD_MUTE_EN 0
`define DACF_R20_SOFT_SYSTEM_RESET 6
`define DACF_R20_BS 5
`define DACF_R20_BYP 4
`define DACF_R20_MONO 3
`define DACF_R20_MONO_CHANNEL_SEL 2
`define DACF_R21_DZ_LSB 1
`define DACF_R21_LINEAR_ZERO_FLAG_EN 0

`define DACF_R16_RST 8'h00
`define DACF_R17_RST 8'h00
`define DACF_R18_RST 8'h00
`define DACF_R19_RST 8'h00
`define DACF_R20_RST 8'h00
`define DACF_R21_RST 8'h01

`define DACF_FMT16 3'h0
`define DACF_FMT20 3'h1
`define DACF_FMT24 3'h2
`define DACF_OS_X8 2'h0
`define DACF_OS_X4 2'h1
`define DACF_OS_X16 2'h2
`define DACF_BS_PATTERN 8'h96

`define DACF_CTL_BITS 5'h10
`define DACF_CTL_HALF 5'h08
`define DACF_EXT_ZERO_WORDS 1024
`define DACF_BS_ZERO_MS 200
`define DACF_BS_CLK_HZ 2822400
`define DACF_BS_ZERO_BYTES \
    (`DACF_BS_ZERO_MS * (`DACF_BS_CLK_HZ / 1000) / 8)

`endif

// ---- dacf_pkg.sv ----
// types shared by the converter front end
package dacf_pkg;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_SHIFT = 3'b010,
        CS_COMMIT = 3'b100
    } dacf_ctl_state_t;

    typedef struct packed {
        logic bs;
        logic ext;
        logic [2:0] fmt;
        logic [1:0] dmf;
        logic bypass_stereo_sel;
        logic det_en;
        logic linear_zero_flag_en;
        logic [1:0] dz;
        logic [1:0] os;
    } dacf_cfg_t;

endpackage : dacf_pkg

// ---- dacf_zero_det.sv ----
// run-length zero detector for one channel
`timescale 1ns/10ps
module dacf_zero_det #(
    parameter int CW = 20
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic strobe,
    input wire logic is_zero,
    input wire logic [CW-1:0] limit,
    output logic flag
);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic flag_r, flag_nxt;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        flag_nxt = flag_r;
        if (!enable) begin
            cnt_nxt = '0;
            flag_nxt = 1'b0;
        end else if (strobe) begin
            if (!is_zero) begin
                cnt_nxt = '0;
                flag_nxt = 1'b0;
            end else if (cnt_r < limit) begin
                cnt_nxt = cnt_r + CW'(1);
                flag_nxt = (cnt_r + CW'(1)) >= limit;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_r <= '0;
            flag_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
        enable && strobe && !is_zero |=> !flag_r)
        else $error("zero flag held after nonzero input");
    chk_flag_count: assert property (@(posedge clock) disable iff (rst)
        $rose(flag_r) |-> cnt_r == limit && $past(strobe) && $past(is_zero))
        else $error("zero flag raised before full run");

endmodule : dacf_zero_det

// ---- dacf_top.sv ----
// converter front end: control port, external filter and bitstream input
`timescale 1ns/10ps
`include "dacf_regs.svh"
module dacf_top
    import dacf_pkg::*;
#(
    parameter int BS_ZERO_BYTES = `DACF_BS_ZERO_BYTES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic serial_bit_clock,
    input wire logic word_clock,
    input wire logic left_data_in,
    input wire logic right_data_in,
    input wire logic ctl_select_n,
    input wire logic ctl_clk,
    input wire logic ctl_din,
    input wire logic [4:0] ext_filter_os,
    output logic ctl_dout,
    output logic ctl_dout_oe,
    output logic [23:0] mod_left,
    output logic [23:0] mod_right,
    output logic mod_valid,
    output logic [9:0] total_osr,
    output logic output_polarity_rev,
    output logic output_enable_ctl,
    output logic mono_mode,
    output logic mono_channel_sel,
    output logic mute_hold,
    output logic filter_bypass_sel,
    output logic bitstream_mode_sel,
    output logic [1:0] fir_response_sel,
    output logic fir_half_rate,
    output logic left_bitstream_out,
    output logic right_bitstream_out,
    output logic left_zero_flag,
    output logic right_zero_flag
);
    localparam int ZW = 20;

    function automatic logic [23:0] align_word(input logic [23:0] sh,
                                               input logic [2:0] fmt);
        unique case (fmt)
            `DACF_FMT16: align_word = {sh[15:0], 8'h00};
            `DACF_FMT20: align_word = {sh[19:0], 4'h0};
            `DACF_FMT24: align_word = sh;
            default: align_word = 24'h00_0000;
        endcase
    endfunction : align_word

    function automatic logic bs_byte_zero(input logic [7:0] b,
                                          input logic [1:0] dz);
        if (dz[1])
            bs_byte_zero = b == `DACF_BS_PATTERN;
        else
            bs_byte_zero = dz[0] && $countones(b) == 4;
    endfunction : bs_byte_zero

    // ----------------------------------------
    // control port, system clock domain
    // ----------------------------------------
    logic [1:0] sel_sy, sck_sy, sdi_sy;
    logic [4:0] eos_s1, eos_s2;
    logic sck_d_r;
    dacf_ctl_state_t cs_r, cs_nxt;
    logic [15:0] csh_r, csh_nxt;
    logic [4:0] ccnt_r, ccnt_nxt;
    logic [7:0] dsh_r, dsh_nxt, rd_data;
    logic rd_r, rd_nxt, dout_r, dout_nxt, doe_r, doe_nxt;
    logic [7:0] r16_r, r17_r, r18_r, r19_r, r20_r, r21_r;
    logic [7:0] r16_nxt, r17_nxt, r18_nxt, r19_nxt, r20_nxt, r21_nxt;
    logic soft_rst_r, soft_rst_nxt, rst_any_r;
    logic [3:0] zst_s1, zst_s2;
    logic zf_l_r, zf_r_r, det_l_w, det_r_w;
    wire sck_rise = sck_sy[1] & ~sck_d_r;
    wire sck_fall = ~sck_sy[1] & sck_d_r;
    wire [6:0] rd_addr = {csh_r[5:0], sdi_sy[1]};
    wire wr_en = cs_r == CS_COMMIT && !rd_r && ccnt_r == `DACF_CTL_BITS;
    wire [6:0] waddr = csh_r[14:8];
    wire [7:0] wdata = csh_r[7:0];
    wire bs_mode = r20_r[`DACF_R20_BS];
    wire ext_mode = r20_r[`DACF_R20_BYP] & ~r20_r[`DACF_R20_BS];

    always_ff @(posedge clock) begin
        sel_sy <= {sel_sy[0], ctl_select_n};
        sck_sy <= {sck_sy[0], ctl_clk};
        sdi_sy <= {sdi_sy[0], ctl_din};
        eos_s1 <= ext_filter_os;
        eos_s2 <= eos_s1;
        sck_d_r <= sck_sy[1];
    end

    always_comb begin
        unique case (rd_addr)
            `DACF_ADDR_R16: rd_data = r16_r;
            `DACF_ADDR_R17: rd_data = r17_r;
            `DACF_ADDR_R18: rd_data = r18_r;
            `DACF_ADDR_R19: rd_data = r19_r;
            `DACF_ADDR_R20: rd_data = r20_r;
            `DACF_ADDR_R21: rd_data = r21_r;
            `DACF_ADDR_R22: rd_data = {6'h00, zst_s2[1:0]};
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        cs_nxt = cs_r;
        csh_nxt = csh_r;
        ccnt_nxt = ccnt_r;
        dsh_nxt = dsh_r;
        rd_nxt = rd_r;
        dout_nxt = dout_r;
        doe_nxt = doe_r;
        unique case (cs_r)
            CS_IDLE: begin
                ccnt_nxt = '0;
                doe_nxt = 1'b0;
                dout_nxt = 1'b0;
                if (!sel_sy[1])
                    cs_nxt = CS_SHIFT;
            end
            CS_SHIFT: begin
                if (sel_sy[1]) begin
                    cs_nxt = CS_COMMIT;
                    doe_nxt = 1'b0;
                    dout_nxt = 1'b0;
                end else if (sck_rise && ccnt_r < `DACF_CTL_BITS) begin
                    csh_nxt = {csh_r[14:0], sdi_sy[1]};
                    ccnt_nxt = ccnt_r + 5'h01;
                    if (ccnt_r == 5'h00)
                        rd_nxt = sdi_sy[1];
                    if (ccnt_r == `DACF_CTL_HALF - 5'h01)
                        dsh_nxt = rd_data;
                end else if (sck_fall && rd_r && ccnt_r >= `DACF_CTL_HALF
                             && ccnt_r < `DACF_CTL_BITS) begin
                    dout_nxt = dsh_r[7];
                    doe_nxt = 1'b1;
                    dsh_nxt = {dsh_r[6:0], 1'b0};
                end
            end
            CS_COMMIT: cs_nxt = CS_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cs_r <= CS_IDLE;
            csh_r <= 16'h0000;
            ccnt_r <= 5'h00;
            dsh_r <= 8'h00;
            rd_r <= 1'b0;
            dout_r <= 1'b0;
            doe_r <= 1'b0;
        end else begin
            cs_r <= cs_nxt;
            csh_r <= csh_nxt;
            ccnt_r <= ccnt_nxt;
            dsh_r <= dsh_nxt;
            rd_r <= rd_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_comb begin
        {r16_nxt, r17_nxt, r18_nxt} = {r16_r, r17_r, r18_r};
        {r19_nxt, r20_nxt, r21_nxt} = {r19_r, r20_r, r21_r};
        soft_rst_nxt = wr_en && waddr == `DACF_ADDR_R20
                       && wdata[`DACF_R20_SOFT_SYSTEM_RESET];
        if (wr_en) begin
            unique case (waddr)
                `DACF_ADDR_R16: r16_nxt = wdata;
                `DACF_ADDR_R17: r17_nxt = wdata;
                `DACF_ADDR_R18: r18_nxt = wdata;
                `DACF_ADDR_R19: r19_nxt = wdata;
                `DACF_ADDR_R20: r20_nxt = {2'h0, wdata[5:0]};
                `DACF_ADDR_R21: r21_nxt = {5'h00, wdata[2:0]};
                default: ; // status register is read only
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst || soft_rst_r) begin
            r16_r <= `DACF_R16_RST;
            r17_r <= `DACF_R17_RST;
            r18_r <= `DACF_R18_RST;
            r19_r <= `DACF_R19_RST;
            r20_r <= `DACF_R20_RST;
            r21_r <= `DACF_R21_RST;
        end else begin
            {r16_r, r17_r, r18_r} <= {r16_nxt, r17_nxt, r18_nxt};
            {r19_r, r20_r, r21_r} <= {r19_nxt, r20_nxt, r21_nxt};
        end
        soft_rst_r <= rst ? 1'b0 : soft_rst_nxt;
        rst_any_r <= rst | soft_rst_r;
    end

    // ----------------------------------------
    // mode outputs and word capture
    // ----------------------------------------
    dacf_cfg_t cfg_r, cfg_nxt;
    logic [2:0] tgl_sy;
    logic [23:0] hold_l_r, hold_r_r, mod_l_r, mod_l_nxt, mod_r_r, mod_r_nxt;
    logic mval_r, mval_nxt, mute_r, mute_nxt, pol_r, pol_nxt, ope_r, ope_nxt;
    logic mono_r, mono_nxt, mono_channel_sel_r, mono_channel_sel_nxt, byp_r, byp_nxt, bss_r, bss_nxt;
    logic [4:0] os_fac;
    logic [9:0] osr_r, osr_nxt;
    logic wtgl_r;

    always_comb begin
        unique case (r20_r[1:0])
            `DACF_OS_X8: os_fac = 5'h08;
            `DACF_OS_X4: os_fac = 5'h04;
            `DACF_OS_X16: os_fac = 5'h10;
            default: os_fac = 5'h00;
        endcase
        // fields not listed for the live mode are forced inert
        cfg_nxt.bs = bs_mode;
        cfg_nxt.ext = ext_mode;
        cfg_nxt.fmt = ext_mode ? r18_r[6:4] : `DACF_FMT16;
        cfg_nxt.dmf = bs_mode ? r18_r[3:2] : 2'h0;
        cfg_nxt.bypass_stereo_sel = ext_mode & r19_r[`DACF_R19_BYPASS_STEREO_SEL];
        cfg_nxt.det_en = ext_mode & (r21_r[`DACF_R21_LINEAR_ZERO_FLAG_EN]
                                     | r19_r[`DACF_R19_ZERO_HOLD_MUTE_EN]);
        cfg_nxt.linear_zero_flag_en = ext_mode & r21_r[`DACF_R21_LINEAR_ZERO_FLAG_EN];
        cfg_nxt.dz = bs_mode ? r21_r[2:1] : 2'h0;
        cfg_nxt.os = r20_r[1:0];
        osr_nxt = ext_mode ? 10'(eos_s2) * 10'(os_fac) : 10'h000;
        pol_nxt = r19_r[`DACF_R19_REV];
        ope_nxt = r19_r[`DACF_R19_OPE];
        mono_nxt = r20_r[`DACF_R20_MONO];
        mono_channel_sel_nxt = r20_r[`DACF_R20_MONO_CHANNEL_SEL];
        byp_nxt = ext_mode;
        bss_nxt = bs_mode;
        mute_nxt = ext_mode & r19_r[`DACF_R19_ZERO_HOLD_MUTE_EN]
                   & zst_s2[2] & zst_s2[3];
        mval_nxt = 1'b0;
        mod_l_nxt = mod_l_r;
        mod_r_nxt = mod_r_r;
        // hold words change with the toggle and stay stable for many cycles after it
        if ((tgl_sy[1] ^ tgl_sy[2]) && ext_mode) begin
            mod_l_nxt = hold_l_r;
            mod_r_nxt = hold_r_r;
            mval_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        tgl_sy <= {tgl_sy[1:0], wtgl_r};
        zst_s1 <= {det_r_w, det_l_w, zf_r_r, zf_l_r};
        zst_s2 <= zst_s1;
        if (rst) begin
            cfg_r <= '0;
            {osr_r, pol_r, ope_r, mono_r, mono_channel_sel_r} <= '0;
            {byp_r, bss_r, mute_r, mval_r} <= '0;
            mod_l_r <= 24'h00_0000;
            mod_r_r <= 24'h00_0000;
        end else begin
            cfg_r <= cfg_nxt;
            {osr_r, pol_r, ope_r, mono_r, mono_channel_sel_r}
                <= {osr_nxt, pol_nxt, ope_nxt, mono_nxt, mono_channel_sel_nxt};
            {byp_r, bss_r, mute_r, mval_r}
                <= {byp_nxt, bss_nxt, mute_nxt, mval_nxt};
            mod_l_r <= mod_l_nxt;
            mod_r_r <= mod_r_nxt;
        end
    end

    // ----------------------------------------
    // link domain, runs on the serial bit clock
    // ----------------------------------------
    logic [1:0] lrst_sy;
    dacf_cfg_t cfg_s1, cfg_s2;
    logic [2:0] wck_sy;
    logic [1:0] dl_sy, dr_sy;
    logic [23:0] sh_l_r, sh_rr, hold_l_nxt, hold_r_nxt;
    logic [7:0] bl_r, br_r;
    logic [2:0] bcnt_r;
    logic bstb_r, bz_l_r, bz_r_r, wtgl_nxt;
    logic [1:0] fir_r;
    logic half_r, bsl_r, bsr_r;
    wire link_rst = lrst_sy[1];
    wire wck_rise = wck_sy[1] & ~wck_sy[2];
    wire [23:0] word_l = align_word(sh_l_r, cfg_s2.fmt);
    wire [23:0] word_r = align_word(cfg_s2.bypass_stereo_sel ? sh_rr : sh_l_r,
                                    cfg_s2.fmt);
    wire zd_stb = cfg_s2.ext ? wck_rise : bstb_r;
    wire zd_l = cfg_s2.ext ? word_l == 24'h00_0000 : bz_l_r;
    wire zd_r = cfg_s2.ext ? word_r == 24'h00_0000 : bz_r_r;
    wire zd_en = cfg_s2.det_en | (cfg_s2.dz != 2'h0);
    wire zf_gate = cfg_s2.linear_zero_flag_en | (cfg_s2.dz != 2'h0);
    wire [ZW-1:0] zd_lim = cfg_s2.ext ? ZW'(`DACF_EXT_ZERO_WORDS)
                                      : ZW'(BS_ZERO_BYTES);

    always_comb begin
        hold_l_nxt = hold_l_r;
        hold_r_nxt = hold_r_r;
        wtgl_nxt = wtgl_r;
        if (wck_rise && cfg_s2.ext) begin
            hold_l_nxt = word_l;
            hold_r_nxt = word_r;
            wtgl_nxt = ~wtgl_r;
        end
    end

    // no system clock edge is needed here once the mode is set
    always_ff @(posedge serial_bit_clock) begin
        lrst_sy <= {lrst_sy[0], rst_any_r};
        cfg_s1 <= cfg_r;
        cfg_s2 <= cfg_s1;
        wck_sy <= {wck_sy[1:0], word_clock};
        dl_sy <= {dl_sy[0], left_data_in};
        dr_sy <= {dr_sy[0], right_data_in};
        sh_l_r <= {sh_l_r[22:0], dl_sy[1]};
        sh_rr <= {sh_rr[22:0], dr_sy[1]};
        if (link_rst) begin
            {hold_l_r, hold_r_r, wtgl_r} <= '0;
            {bl_r, br_r, bcnt_r, bstb_r, bz_l_r, bz_r_r} <= '0;
            {fir_r, half_r, bsl_r, bsr_r, zf_l_r, zf_r_r} <= '0;
        end else begin
            hold_l_r <= hold_l_nxt;
            hold_r_r <= hold_r_nxt;
            wtgl_r <= wtgl_nxt;
            bl_r <= {bl_r[6:0], dl_sy[1]};
            br_r <= {br_r[6:0], dr_sy[1]};
            bcnt_r <= cfg_s2.bs ? bcnt_r + 3'h1 : 3'h0;
            bstb_r <= cfg_s2.bs && bcnt_r == 3'h7;
            if (bcnt_r == 3'h7) begin
                bz_l_r <= bs_byte_zero({bl_r[6:0], dl_sy[1]}, cfg_s2.dz);
                bz_r_r <= bs_byte_zero({br_r[6:0], dr_sy[1]}, cfg_s2.dz);
            end
            fir_r <= cfg_s2.dmf;
            half_r <= cfg_s2.bs && cfg_s2.os == `DACF_OS_X4;
            bsl_r <= cfg_s2.bs & dl_sy[1];
            bsr_r <= cfg_s2.bs & dr_sy[1];
            zf_l_r <= det_l_w & zf_gate;
            zf_r_r <= det_r_w & zf_gate;
        end
    end

    dacf_zero_det #(.CW(ZW)) u_zero_left (
        .clock(serial_bit_clock), .rst(link_rst), .enable(zd_en),
        .strobe(zd_stb), .is_zero(zd_l), .limit(zd_lim), .flag(det_l_w));
    dacf_zero_det #(.CW(ZW)) u_zero_right (
        .clock(serial_bit_clock), .rst(link_rst), .enable(zd_en),
        .strobe(zd_stb), .is_zero(zd_r), .limit(zd_lim), .flag(det_r_w));

    assign {ctl_dout, ctl_dout_oe, mod_valid} = {dout_r, doe_r, mval_r};
    assign {mod_left, mod_right, total_osr} = {mod_l_r, mod_r_r, osr_r};
    assign {output_polarity_rev, output_enable_ctl} = {pol_r, ope_r};
    assign {mono_mode, mono_channel_sel, mute_hold} = {mono_r, mono_channel_sel_r, mute_r};
    assign {filter_bypass_sel, bitstream_mode_sel} = {byp_r, bss_r};
    assign {fir_response_sel, fir_half_rate} = {fir_r, half_r};
    assign {left_bitstream_out, right_bitstream_out} = {bsl_r, bsr_r};
    assign {left_zero_flag, right_zero_flag} = {zf_l_r, zf_r_r};

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_osr_product: assert property (@(posedge clock) disable iff (rst)
        ext_mode && r20_r[1:0] == `DACF_OS_X16 |=>
            osr_r == 10'($past(eos_s2)) * 10'h010)
        else $error("total oversampling ratio wrong");
    chk_mute_mode: assert property (@(posedge clock) disable iff (rst)
        !ext_mode |=> !mute_r)
        else $error("zero mute active outside external mode");
    chk_soft_reset: assert property (@(posedge clock) disable iff (rst)
        soft_rst_r |=> r20_r == `DACF_R20_RST && r21_r == `DACF_R21_RST)
        else $error("soft reset did not restore defaults");
    chk_write_commit: assert property (@(posedge clock) disable iff (rst)
        wr_en && waddr == `DACF_ADDR_R19 |=> r19_r == $past(wdata))
        else $error("control write not stored");
    chk_read_drive: assert property (@(posedge clock) disable iff (rst)
        $rose(doe_r) |-> rd_r && ccnt_r >= `DACF_CTL_HALF)
        else $error("readback driven outside a read");
    chk_valid_mode: assert property (@(posedge clock) disable iff (rst)
        mval_r |-> $past(ext_mode) ##1 !mval_r)
        else $error("word delivered outside external mode");
    chk_fir_gated: assert property (@(posedge serial_bit_clock)
        disable iff (link_rst) !cfg_s2.bs |=> fir_r == 2'h0 && !half_r)
        else $error("fir controls live outside bitstream mode");
    chk_align16: assert property (@(posedge serial_bit_clock)
        disable iff (link_rst) wck_rise && cfg_s2.ext
            && cfg_s2.fmt == `DACF_FMT16 |=> hold_l_r[7:0] == 8'h00)
        else $error("short word not left aligned");
    cov_word: cover property (@(posedge clock) disable iff (rst) mval_r);
    cov_write: cover property (@(posedge clock) disable iff (rst) wr_en);
    cov_read: cover property (@(posedge clock) disable iff (rst) $rose(doe_r));
    cov_mute: cover property (@(posedge clock) disable iff (rst) mute_r);

endmodule : dacf_top

// ---- dacf_src.sv ----
// far-side source model: word clock, bit clock and serial data
`timescale 1ns/10ps
module dacf_src (
    output logic serial_bit_clock,
    output logic word_clock,
    output logic left_data_in,
    output logic right_data_in
);
    // ----
    // burst driver
    // ----
    // the bit clock stands still between bursts, so sync flops see no edges
    initial begin
        serial_bit_clock = 1'b0;
        word_clock = 1'b0;
        left_data_in = 1'b0;
        right_data_in = 1'b1;
    end
    task automatic send(input logic [31:0] l, input logic [31:0] r,
            input int n, input logic wc);
        #7;
        word_clock = wc;
        for (int i = 31; i > 31 - n; i--) begin
            left_data_in = l[i];
            right_data_in = r[i];
            #24 serial_bit_clock = 1'b1;
            #24 serial_bit_clock = 1'b0;
        end
        // released lines show the inverse, never the last bit
        left_data_in = ~left_data_in;
        right_data_in = ~right_data_in;
    endtask : send
endmodule : dacf_src

// ---- test_dacf_top.sv ----
// self-checking bench for the converter front end
`timescale 1ns/10ps
module test_dacf_top;
    // ----
    // signals and instances
    // ----
    logic clock = 1'b0;
    logic run = 1'b1;
    logic rst = 1'b1;
    logic ctl_select_n = 1'b1;
    logic ctl_clk = 1'b1;
    logic ctl_din = 1'b0;
    logic serial_bit_clock, word_clock, left_data_in, right_data_in;
    logic ctl_dout, filter_bypass_sel, bitstream_mode_sel, fir_half_rate;
    logic left_zero_flag, right_zero_flag;
    logic output_polarity_rev, output_enable_ctl, mono_mode, mono_channel_sel;
    logic ctl_dout_oe, left_bitstream_out, right_bitstream_out;
    logic [23:0] mod_left, mod_right;
    logic [9:0] total_osr;
    logic [1:0] fir_response_sel;
    int bad_count = 0;
    int checks_done = 0;
    always #2 clock = run ? ~clock : clock;
    dacf_src dacf_src_i (.serial_bit_clock, .word_clock, .left_data_in,
        .right_data_in);
    dacf_top #(.BS_ZERO_BYTES(16)) dacf_top_i (.clock, .rst,
        .serial_bit_clock, .word_clock, .left_data_in, .right_data_in,
        .ctl_select_n, .ctl_clk, .ctl_din, .ext_filter_os(5'h08), .ctl_dout,
        .ctl_dout_oe, .mod_left, .mod_right, .mod_valid(), .total_osr,
        .output_polarity_rev, .output_enable_ctl, .mono_mode,
        .mono_channel_sel, .mute_hold(), .filter_bypass_sel,
        .bitstream_mode_sel, .fir_response_sel, .fir_half_rate,
        .left_bitstream_out, .right_bitstream_out, .left_zero_flag,
        .right_zero_flag);
    // ----
    // helpers
    // ----
    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // slow phases: the pins pass through two sync flops on clock
    task automatic ctl(input logic [15:0] w, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clock) ctl_select_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clock) ctl_clk <= 1'b0;
            ctl_din <= w[i];
            repeat (5) @(posedge clock);
            if (i < 8) begin
                rd = {rd[6:0], ctl_dout};
            end
            ctl_clk <= 1'b1;
            repeat (5) @(posedge clock);
        end
        ctl_select_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask : ctl
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] v;
        ctl({1'b0, a, d}, v);
    endtask : wr
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] v;
        ctl({1'b1, a, 8'h00}, v);
        chk({16'h0000, v}, {16'h0000, e});
    endtask : rdc
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        logic [7:0] v;
        rdc(7'h15, 8'h01);
        rdc(7'h14, 8'h00);
        ctl(16'h1655, v);
        rdc(7'h16, 8'h00);
        rdc(7'h30, 8'h00);
        chk(24'(ctl_dout_oe), 24'h0);
        wr(7'h15, 8'h06);
        wr(7'h14, 8'h40);
        rdc(7'h15, 8'h01);
        $display("test regs done");
    endtask : t_regs
    task automatic t_osr();
        logic [9:0] e [4] = '{10'h040, 10'h020, 10'h080, 10'h000};
        for (int c = 0; c < 4; c++) begin
            wr(7'h14, 8'h10 | 8'(c));
            repeat (4) @(posedge clock);
            chk(24'(total_osr), 24'(e[c]));
            chk(24'(filter_bypass_sel), 24'h1);
        end
        $display("test osr done");
    endtask : t_osr
    task automatic t_ext();
        logic [23:0] l = 24'h9a_5c3e;
        logic [23:0] r = 24'h3c_a5f1;
        wr(7'h13, 8'h94);
        wr(7'h14, 8'h1c);
        for (int f = 0; f < 3; f++) begin
            wr(7'h12, 8'(f << 4) | 8'h0c);
            dacf_src_i.send({l, 8'h00}, {r, 8'h00}, 24, 1'b0);
            dacf_src_i.send(32'haaaa_aaaa, 32'h5555_5555, 8, 1'b1);
            repeat (4) @(posedge clock);
            chk(mod_left, l << (8 - 4 * f));
            chk(mod_right, r << (8 - 4 * f));
            chk(24'(fir_response_sel), 24'h0);
        end
        chk(24'({output_polarity_rev, output_enable_ctl, mono_mode,
                 mono_channel_sel}), 24'hf);
        $display("test ext done");
    endtask : t_ext
    task automatic t_bs();
        wr(7'h12, 8'h0c);
        wr(7'h15, 8'h02);
        wr(7'h14, 8'h01);
        wr(7'h14, 8'h21);
        run = 1'b0;
        for (int k = 0; k < 6; k++) begin
            dacf_src_i.send(32'h5555_5555, 32'h0000_0000, 32, 1'b0);
        end
        chk(24'(fir_response_sel), 24'h3);
        chk(24'(fir_half_rate), 24'h1);
        chk(24'({right_zero_flag, left_zero_flag}), 24'h1);
        chk(24'({right_bitstream_out, left_bitstream_out}), 24'h1);
        run = 1'b1;
        repeat (4) @(posedge clock);
        chk(24'(bitstream_mode_sel), 24'h1);
        chk(24'(total_osr), 24'h0);
        rdc(7'h16, 8'h01);
        $display("test bitstream done");
    endtask : t_bs
    initial begin
        dacf_src_i.send(32'h0000_0000, 32'h0000_0000, 4, 1'b0);
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        t_regs();
        t_osr();
        t_ext();
        t_bs();
        results();
    end
    initial begin
        #200_000;
        bad_count++;
        results();
    end
endmodule : test_dacf_top
